/* File: verilog/gpio_bank_pkg.sv */
// Package for the three-port GPIO bank: register indices, widths, reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses, one word per index.
package gpio_bank_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [3:0] IDX_C_DATA = 4'h0;
    localparam logic [3:0] IDX_C_DIR = 4'h1;
    localparam logic [3:0] IDX_C_OPT = 4'h2;
    localparam logic [3:0] IDX_B_DATA = 4'h4;
    localparam logic [3:0] IDX_B_DIR = 4'h5;
    localparam logic [3:0] IDX_B_OPT = 4'h6;
    localparam logic [3:0] IDX_A_DATA = 4'h8;
    localparam logic [3:0] IDX_A_DIR = 4'h9;
    localparam logic [3:0] IDX_A_OPT = 4'hA;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'hC;
    localparam logic [3:0] IDX_IRQ_MASK = 4'hD;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int PORT_W = 8;
    localparam int PORT_C_PINS = 6;
    localparam int IRQ_W = 3;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Interrupt status bit positions, one per port group.
    localparam int IRQ_BIT_A = 0;
    localparam int IRQ_BIT_B = 1;
    localparam int IRQ_BIT_C = 2;

endpackage

/* File: verilog/gpio_port.sv */
// One 8-bit GPIO port: latch, direction, option, pad control and interrupt level.
// Assumes registers are written by the parent; pad inputs may be asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none
module gpio_port #(
    parameter int WIDTH = 8,
    parameter bit HAS_PULLUP = 1'b1,
    parameter bit TRUE_OPEN_DRAIN = 1'b0
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register writes.
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic wr_opt,
    input wire logic [WIDTH-1:0] wr_value,
    // Register contents.
    output logic [WIDTH-1:0] data_q,
    output logic [WIDTH-1:0] dir_q,
    output logic [WIDTH-1:0] opt_q,
    output logic [WIDTH-1:0] read_value,
    // Alternate function from peripherals.
    input wire logic [WIDTH-1:0] alt_en,
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_push_pull,
    // Pads.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_pullup,
    // Combined interrupt level.
    output logic irq_level,
    output logic irq_any_en
);
    import gpio_bank_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] opt_reg;

    // Latch, direction and option registers; data latch written in any mode.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= WIDTH'(PORT_RESET); // R7
            dir_reg <= WIDTH'(PORT_RESET); // R7
            opt_reg <= WIDTH'(PORT_RESET); // R7
        end else begin
            if (wr_data) data_reg <= wr_value; // R2 R16
            if (wr_dir) dir_reg <= wr_value; // R1 R16
            if (wr_opt) opt_reg <= wr_value; // R16
        end
    end

    // Two-stage synchroniser on the pad inputs.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_in; // R16
            sync_reg <= meta_reg; // R16
        end
    end

    // ************************************************************
    // Pad control, per bit
    // ************************************************************
    logic [WIDTH-1:0] out_mode;
    logic [WIDTH-1:0] drive_val;
    logic [WIDTH-1:0] push_pull;
    logic [WIDTH-1:0] irq_en;

    // Bit n of every register steers pin n; alternate function overrides.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign out_mode[i] = dir_reg[i] | alt_en[i]; // R1 R8 R12 R15
            assign drive_val[i] = alt_en[i] ? alt_out[i] : data_reg[i]; // R15
            // Port A never drives high; others push-pull with option set, or with alt_push_pull when claimed.
            assign push_pull[i] = alt_en[i] ? (alt_push_pull[i] & !TRUE_OPEN_DRAIN)
                                : (opt_reg[i] & !TRUE_OPEN_DRAIN); // R5 R6
            // Low is always driven; high only in push-pull.
            assign pin_oe[i] = out_mode[i] & (!drive_val[i] | push_pull[i]); // R5 R6
            assign pin_out[i] = drive_val[i];
            assign irq_en[i] = !out_mode[i] & opt_reg[i]; // R4 R13
            assign pin_pullup[i] = HAS_PULLUP & irq_en[i]; // R4
            assign read_value[i] = dir_reg[i] ? data_reg[i] : sync_reg[i]; // R3
        end
    endgenerate

    // Enabled inputs are ANDed; disabled pins count as high.
    assign irq_level = &(sync_reg | ~irq_en); // R14
    assign irq_any_en = |irq_en;

    assign data_q = data_reg;
    assign dir_q = dir_reg;
    assign opt_q = opt_reg;

endmodule
`default_nettype wire

/* File: verilog/gpio_bank.sv */
// Three-port GPIO bank with Wishbone register access and a falling-edge interrupt.
// Assumes classic Wishbone, 32-bit data, byte addresses, one 20 MHz clock.
// Notes on behaviour
// R1 - Direction bit cleared means input, set means output.
// R2 - Data writes always update the output latch, even for inputs.
// R3 - Data read gives latch for outputs, synchronised pin level for inputs.
// R4 - Input option set enables interrupt; pull-up on ports B and C only.
// R5 - Ports B and C output: option clear open drain, set push-pull.
// R6 - Port A output is open drain; option set is reserved for software.
// R7 - Reset clears data, direction and option registers of every port.
// R8 - Pins without an option bit are configured by direction alone.
// R9 - Converter input pins must be floating inputs, set by software.
// R10 - Avoid changing pin level or load during a conversion.
// R11 - Software uses only the safe configuration transitions.
// R12 - Bit n of each port register belongs to pin n.
// R13 - Output pins never generate interrupts.
// R14 - Interrupt-enabled inputs of a port are ANDed before detection.
// R15 - A peripheral claiming a pin overrides port programming as output.
// R16 - Writes act at the next edge; inputs are synchronised first.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gpio_bank (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt.
    output logic irq,
    // Port A pins.
    input wire logic [gpio_bank_pkg::PORT_W-1:0] first_port_pins_in,
    output logic [gpio_bank_pkg::PORT_W-1:0] first_port_pins_out,
    output logic [gpio_bank_pkg::PORT_W-1:0] first_port_pins_oe,
    // Port B pins.
    input wire logic [gpio_bank_pkg::PORT_W-1:0] second_port_pins_in,
    output logic [gpio_bank_pkg::PORT_W-1:0] second_port_pins_out,
    output logic [gpio_bank_pkg::PORT_W-1:0] second_port_pins_oe,
    output logic [gpio_bank_pkg::PORT_W-1:0] second_port_pullup,
    // Port C pins.
    input wire logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pins_in,
    output logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pins_out,
    output logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pins_oe,
    output logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pullup,
    // Peripheral alternate functions, A then B then C.
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_en,
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_out,
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_push_pull
);
    import gpio_bank_pkg::*;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [3:0] idx;
    logic req;
    logic wr_ok;
    logic rd_ok;
    logic lane0;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Single-cycle answer: ack one cycle after the request, then dropped.
    assign idx = wb_adr_i[5:2];
    assign req = wb_cyc_i & wb_stb_i & !ack_reg;
    assign lane0 = wb_sel_i[0];
    assign wr_ok = req & wb_we_i & lane0;
    assign rd_ok = req & !wb_we_i;

    // Pin-side vectors; port C widened to eight bits with unused pins tied high.
    logic [PORT_W-1:0] c_pin_in;
    logic [PORT_W-1:0] c_out;
    logic [PORT_W-1:0] c_oe;
    logic [PORT_W-1:0] c_pu;
    logic [PORT_W-1:0] a_pu_unused;
    // Register contents and read values of each port.
    logic [PORT_W-1:0] a_data;
    logic [PORT_W-1:0] a_dir;
    logic [PORT_W-1:0] a_opt;
    logic [PORT_W-1:0] a_rd;
    logic [PORT_W-1:0] b_data;
    logic [PORT_W-1:0] b_dir;
    logic [PORT_W-1:0] b_opt;
    logic [PORT_W-1:0] b_rd;
    logic [PORT_W-1:0] c_data;
    logic [PORT_W-1:0] c_dir;
    logic [PORT_W-1:0] c_opt;
    logic [PORT_W-1:0] c_rd;
    logic [PORT_W-1:0] c_alt_en;
    logic [IRQ_W-1:0] lvl;
    logic [IRQ_W-1:0] lvl_en;
    assign c_pin_in = {{(PORT_W-PORT_C_PINS){1'b1}}, third_port_pins_in};
    // Pins C6 and C7 do not exist; they never claim a peripheral.
    assign c_alt_en = {{(PORT_W-PORT_C_PINS){1'b0}}, alt_en[3*PORT_W-3:2*PORT_W]};

    // ************************************************************
    // Write strobes
    // ************************************************************
    // A write with lane 0 off is acknowledged but raises no strobe.
    logic wr_a_data;
    logic wr_a_dir;
    logic wr_a_opt;
    logic wr_b_data;
    logic wr_b_dir;
    logic wr_b_opt;
    logic wr_c_data;
    logic wr_c_dir;
    logic wr_c_opt;
    logic wr_mask;
    // One strobe per register except the read-only status; a write acts at the edge that takes it.
    assign wr_a_data = wr_ok && idx == IDX_A_DATA; // R16
    assign wr_a_dir = wr_ok && idx == IDX_A_DIR;
    assign wr_a_opt = wr_ok && idx == IDX_A_OPT;
    assign wr_b_data = wr_ok && idx == IDX_B_DATA;
    assign wr_b_dir = wr_ok && idx == IDX_B_DIR;
    assign wr_b_opt = wr_ok && idx == IDX_B_OPT;
    assign wr_c_data = wr_ok && idx == IDX_C_DATA;
    assign wr_c_dir = wr_ok && idx == IDX_C_DIR;
    assign wr_c_opt = wr_ok && idx == IDX_C_OPT;
    assign wr_mask = wr_ok && idx == IDX_IRQ_MASK;

    // ************************************************************
    // Ports
    // ************************************************************
    // Port A: true open drain, no pull-up.
    gpio_port #(.WIDTH(PORT_W), .HAS_PULLUP(1'b0), .TRUE_OPEN_DRAIN(1'b1)) u_port_a (
        .clock(clock),
        .rst_n(rst_n),
        .wr_data(wr_a_data),
        .wr_dir(wr_a_dir),
        .wr_opt(wr_a_opt),
        .wr_value(wb_dat_i[7:0]),
        .data_q(a_data),
        .dir_q(a_dir),
        .opt_q(a_opt),
        .read_value(a_rd),
        .alt_en(alt_en[PORT_W-1:0]),
        .alt_out(alt_out[PORT_W-1:0]),
        .alt_push_pull(alt_push_pull[PORT_W-1:0]),
        .pin_in(first_port_pins_in),
        .pin_out(first_port_pins_out),
        .pin_oe(first_port_pins_oe),
        .pin_pullup(a_pu_unused),
        .irq_level(lvl[IRQ_BIT_A]),
        .irq_any_en(lvl_en[IRQ_BIT_A])
    );

    // Port B: logic-level open drain or push-pull, pull-up with interrupt.
    gpio_port #(.WIDTH(PORT_W), .HAS_PULLUP(1'b1), .TRUE_OPEN_DRAIN(1'b0)) u_port_b (
        .clock(clock),
        .rst_n(rst_n),
        .wr_data(wr_b_data),
        .wr_dir(wr_b_dir),
        .wr_opt(wr_b_opt),
        .wr_value(wb_dat_i[7:0]),
        .data_q(b_data),
        .dir_q(b_dir),
        .opt_q(b_opt),
        .read_value(b_rd),
        .alt_en(alt_en[2*PORT_W-1:PORT_W]),
        .alt_out(alt_out[2*PORT_W-1:PORT_W]),
        .alt_push_pull(alt_push_pull[2*PORT_W-1:PORT_W]),
        .pin_in(second_port_pins_in),
        .pin_out(second_port_pins_out),
        .pin_oe(second_port_pins_oe),
        .pin_pullup(second_port_pullup),
        .irq_level(lvl[IRQ_BIT_B]),
        .irq_any_en(lvl_en[IRQ_BIT_B])
    );

    // Port C: six pins, same modes as port B.
    gpio_port #(.WIDTH(PORT_W), .HAS_PULLUP(1'b1), .TRUE_OPEN_DRAIN(1'b0)) u_port_c (
        .clock(clock),
        .rst_n(rst_n),
        .wr_data(wr_c_data),
        .wr_dir(wr_c_dir),
        .wr_opt(wr_c_opt),
        .wr_value(wb_dat_i[7:0]),
        .data_q(c_data),
        .dir_q(c_dir),
        .opt_q(c_opt),
        .read_value(c_rd),
        .alt_en(c_alt_en),
        .alt_out(alt_out[3*PORT_W-1:2*PORT_W]),
        .alt_push_pull(alt_push_pull[3*PORT_W-1:2*PORT_W]),
        .pin_in(c_pin_in),
        .pin_out(c_out),
        .pin_oe(c_oe),
        .pin_pullup(c_pu),
        .irq_level(lvl[IRQ_BIT_C]),
        .irq_any_en(lvl_en[IRQ_BIT_C])
    );

    assign third_port_pins_out = c_out[PORT_C_PINS-1:0];
    assign third_port_pins_oe = c_oe[PORT_C_PINS-1:0];
    assign third_port_pullup = c_pu[PORT_C_PINS-1:0];

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [IRQ_W-1:0] lvl_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] fall;
    logic status_rd;

    // A falling edge of the ANDed level of a group is the event.
    assign fall = lvl_reg & ~lvl & lvl_en; // R13 R14
    assign status_rd = rd_ok && idx == IDX_IRQ_STATUS;
    // Reading clears the status, but an event in that cycle still sets it.
    assign status_next = (status_rd ? IRQ_RESET : status_reg) | fall;

    // Level history; reset high so that no false edge follows reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lvl_reg <= {IRQ_W{1'b1}};
        end else begin
            lvl_reg <= lvl;
        end
    end

    // Sticky status, set by an event and cleared by a read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= IRQ_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Mask register, written from the low bits of the bus data.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= IRQ_RESET;
        end else if (wr_mask) begin
            mask_reg <= wb_dat_i[IRQ_W-1:0];
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ************************************************************
    // Read mux
    // ************************************************************
    // Data reads reflect pins for inputs and latch for outputs.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (idx == IDX_A_DATA) begin
            rdata_next[7:0] = a_rd; // R3
        end else if (idx == IDX_A_DIR) begin
            rdata_next[7:0] = a_dir;
        end else if (idx == IDX_A_OPT) begin
            rdata_next[7:0] = a_opt;
        end else if (idx == IDX_B_DATA) begin
            rdata_next[7:0] = b_rd; // R3
        end else if (idx == IDX_B_DIR) begin
            rdata_next[7:0] = b_dir;
        end else if (idx == IDX_B_OPT) begin
            rdata_next[7:0] = b_opt;
        end else if (idx == IDX_C_DATA) begin
            rdata_next[5:0] = c_rd[5:0]; // R3
        end else if (idx == IDX_C_DIR) begin
            rdata_next[7:0] = c_dir;
        end else if (idx == IDX_C_OPT) begin
            rdata_next[7:0] = c_opt;
        end else if (idx == IDX_IRQ_STATUS) begin
            rdata_next[IRQ_W-1:0] = status_reg;
        end else if (idx == IDX_IRQ_MASK) begin
            rdata_next[IRQ_W-1:0] = mask_reg;
        end
    end

    // Answer register; unmapped addresses ack with zero data.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (rd_ok) rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Data latch of unused port C bits is kept but never reaches a pin.
    logic unused_ok;
    assign unused_ok = &{1'b0, c_data, a_data, b_data, a_pu_unused, c_out[7:6],
                         c_oe[7:6], c_pu[7:6], alt_en[3*PORT_W-1:3*PORT_W-2], c_rd[7:6]};

endmodule
`default_nettype wire

/* File: testbench/gpio_bank_sva.sv */
// Checker for the GPIO bank: bus handshake, pad drive rules and reset state.
// Sees only the top ports; bound into every gpio_bank instance.
`timescale 1ns/10ps
`default_nettype none
module gpio_bank_sva (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq,
    // Pads.
    input wire logic [gpio_bank_pkg::PORT_W-1:0] first_port_pins_out,
    input wire logic [gpio_bank_pkg::PORT_W-1:0] first_port_pins_oe,
    input wire logic [gpio_bank_pkg::PORT_W-1:0] second_port_pins_out,
    input wire logic [gpio_bank_pkg::PORT_W-1:0] second_port_pins_oe,
    input wire logic [gpio_bank_pkg::PORT_W-1:0] second_port_pullup,
    input wire logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pins_oe,
    input wire logic [gpio_bank_pkg::PORT_C_PINS-1:0] third_port_pullup,
    // Peripheral overrides.
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_en,
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_out,
    input wire logic [3*gpio_bank_pkg::PORT_W-1:0] alt_push_pull
);
    import gpio_bank_pkg::*;
    // ************************************************************
    // Properties
    // ************************************************************
    // A request is taken when it meets a low acknowledge.
    wire taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0] b_pp = alt_en[15:8] & alt_push_pull[15:8];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_ack_follows: assert property (taken |=> wb_ack_o)
        else $error("request not acknowledged one cycle later");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    chk_reset_quiet: assert property ($rose(rst_n) && alt_en == '0 |->
        first_port_pins_oe == '0 && second_port_pins_oe == '0 && third_port_pins_oe == '0 && !irq)
        else $error("pads driven or interrupt raised after reset");
    chk_a_open_drain: assert property (
        (first_port_pins_oe & first_port_pins_out & ~(alt_en[7:0] & alt_push_pull[7:0])) == '0)
        else $error("first port drives a high level");
    chk_b_pullup_off: assert property ((second_port_pullup & second_port_pins_oe) == '0)
        else $error("second port pull-up on a driven pin");
    chk_c_pullup_off: assert property ((third_port_pullup & third_port_pins_oe) == '0)
        else $error("third port pull-up on a driven pin");
    chk_alt_drive: assert property (
        (b_pp & ~(second_port_pins_oe & ~(second_port_pins_out ^ alt_out[15:8]))) == '0)
        else $error("peripheral output not driven on second port");
    chk_dir_clear: assert property (taken && wb_we_i && wb_sel_i[0] &&
        wb_adr_i[5:2] == IDX_B_DIR && wb_dat_i[7:0] == 8'h00 |=>
        alt_en[15:8] != 8'h00 || second_port_pins_oe == 8'h00)
        else $error("cleared direction still drives");
    chk_c_unused_zero: assert property (
        taken && !wb_we_i && wb_adr_i[5:2] == IDX_C_DATA |=> wb_dat_o[31:6] == 26'h0)
        else $error("absent third port pins read nonzero");
    cover property (taken && wb_we_i);
    cover property (taken && !wb_we_i);
    cover property ($rose(irq));
endmodule
bind gpio_bank gpio_bank_sva chk_i (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .first_port_pins_out, .first_port_pins_oe,
    .second_port_pins_out, .second_port_pins_oe, .second_port_pullup, .third_port_pins_oe,
    .third_port_pullup, .alt_en, .alt_out, .alt_push_pull);
`default_nettype wire

/* File: testbench/pad_world.sv */
// Board model around one port: external drivers, pull-ups and pad level.
// Assumes the bench sets drive_en and drive_val; runs on the bank clock.
`timescale 1ns/10ps
`default_nettype none
module pad_world #(
    parameter int W = 8
) (
    // Clock.
    input wire logic clock,
    // Bank pad controls.
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pull_en,
    // External drivers.
    input wire logic [W-1:0] drive_en,
    input wire logic [W-1:0] drive_val,
    // Level seen at the pads.
    output logic [W-1:0] level
);
    logic [W-1:0] float_reg = '0;
    // An undriven pad without pull-up wanders, so a stale value never passes.
    always_ff @(posedge clock) begin
        float_reg <= ~float_reg;
    end
    // The bank wins where it drives; otherwise the board driver, pull-up or noise.
    assign level = (oe & out) | (~oe & drive_en & drive_val) |
        (~oe & ~drive_en & (pull_en | float_reg));
endmodule
`default_nettype wire

/* File: testbench/three_port_gpio_bank_tb.sv */
// Self-checking bench for the GPIO bank: registers, pads, interrupt, reset.
// Assumes gpio_bank_pkg, the bank and the pad_world board model.
`timescale 1ns/10ps
`default_nettype none
module three_port_gpio_bank_tb;
    import gpio_bank_pkg::*;
    typedef struct packed {logic [3:0] idx; logic [7:0] d; logic [7:0] e;} row_t;
    logic clock = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = '0, q;
    logic [23:0] alt_en = '0, alt_out = '0, alt_push_pull = '0;
    logic [7:0] b_val = 8'h00, ext_en = 8'hFF;
    logic [5:0] c_val = 6'h15;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, irq;
    wire logic [7:0] first_port_pins_in, first_port_pins_out, first_port_pins_oe;
    wire logic [7:0] second_port_pins_in, second_port_pins_out, second_port_pins_oe;
    wire logic [7:0] second_port_pullup;
    wire logic [5:0] third_port_pins_in, third_port_pins_out, third_port_pins_oe, third_port_pullup;
    int err_count = 0, n_tests = 0;
    // Data is written before direction, so outputs start at a known level.
    row_t rows [7] = '{'{IDX_B_DATA, 8'hA5, 8'h00}, '{IDX_B_DIR, 8'hFF, 8'hFF},
        '{IDX_B_OPT, 8'h0F, 8'h0F}, '{IDX_A_DATA, 8'h3C, 8'h00}, '{IDX_A_DIR, 8'hFF, 8'hFF},
        '{IDX_C_OPT, 8'h2A, 8'h2A}, '{IDX_IRQ_MASK, 8'h05, 8'h05}};
    gpio_bank dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .first_port_pins_in, .first_port_pins_out,
        .first_port_pins_oe, .second_port_pins_in, .second_port_pins_out, .second_port_pins_oe,
        .second_port_pullup, .third_port_pins_in, .third_port_pins_out, .third_port_pins_oe,
        .third_port_pullup, .alt_en, .alt_out, .alt_push_pull);
    pad_world #(.W(8)) pads_a (.clock, .out(first_port_pins_out), .oe(first_port_pins_oe),
        .pull_en(8'h00), .drive_en(ext_en), .drive_val(8'h00), .level(first_port_pins_in));
    pad_world #(.W(8)) pads_b (.clock, .out(second_port_pins_out), .oe(second_port_pins_oe),
        .pull_en(second_port_pullup), .drive_en(ext_en), .drive_val(b_val),
        .level(second_port_pins_in));
    pad_world #(.W(6)) pads_c (.clock, .out(third_port_pins_out), .oe(third_port_pins_oe),
        .pull_en(third_port_pullup), .drive_en(ext_en[5:0]), .drive_val(c_val),
        .level(third_port_pins_in));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until acknowledge; read data lands in q.
    task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        ck({31'h0, wb_ack_o}, 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rc(input logic [3:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 32'h0);
        ck(q, e);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Clock, watchdog and test sequence
    // ************************************************************
    initial begin
        forever #25 clock = ~clock;
    end
    initial begin
        #200000;
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) rc(rows[i].idx, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, rows[i].idx, {24'h0, rows[i].d});
            rc(rows[i].idx, {24'h0, rows[i].e});
        end
        rc(IDX_B_DATA, 32'hA5);
        rc(IDX_A_DATA, 32'h3C);
        ck(32'(second_port_pins_oe), 32'h5F);
        ck(32'(second_port_pins_out[3:0]), 32'h5);
        wb(1'b1, IDX_A_OPT, 32'h00);
        ck(32'(first_port_pins_oe), 32'hC3);
        wb_sel_i <= 4'h0;
        wb(1'b1, IDX_B_OPT, 32'hFF);
        wb_sel_i <= 4'h1;
        rc(IDX_B_OPT, 32'h0F);
        rc(IDX_C_DATA, 32'h15);
        rc(4'hF, 32'h0);
        b_val <= 8'h01;
        wb(1'b1, IDX_B_DIR, 32'h0);
        wb(1'b1, IDX_B_OPT, 32'h03);
        wb(1'b1, IDX_IRQ_MASK, 32'h2);
        wb(1'b0, IDX_IRQ_STATUS, 32'h0);
        ck(32'(second_port_pullup), 32'h03);
        rc(IDX_B_DATA, 32'h01);
        b_val <= 8'h00;
        repeat (6) @(posedge clock);
        ck(32'(irq), 32'h0);
        b_val <= 8'h03;
        repeat (6) @(posedge clock);
        b_val <= 8'h02;
        repeat (6) @(posedge clock);
        ck(32'(irq), 32'h1);
        rc(IDX_IRQ_STATUS, 32'h2);
        ck(32'(irq), 32'h0);
        wb(1'b1, IDX_IRQ_MASK, 32'h0);
        b_val <= 8'h03;
        repeat (6) @(posedge clock);
        b_val <= 8'h02;
        repeat (6) @(posedge clock);
        ck(32'(irq), 32'h0);
        rc(IDX_IRQ_STATUS, 32'h2);
        wb(1'b1, IDX_B_DATA, 32'h03);
        wb(1'b1, IDX_B_DIR, 32'hFF);
        wb(1'b0, IDX_IRQ_STATUS, 32'h0);
        wb(1'b1, IDX_B_DATA, 32'h00);
        repeat (6) @(posedge clock);
        rc(IDX_IRQ_STATUS, 32'h0);
        alt_en <= 24'h000100;
        alt_out <= 24'h000100;
        alt_push_pull <= 24'h000100;
        repeat (2) @(posedge clock);
        ck(32'({second_port_pins_oe[0], second_port_pins_out[0]}), 32'h3);
        alt_en <= '0;
        ext_en <= 8'h10;
        wb(1'b1, IDX_C_DATA, 32'h0A);
        wb(1'b1, IDX_C_DIR, 32'h0F);
        ck(32'({third_port_pins_oe, third_port_pins_out}), 32'h3CA);
        ck(32'(third_port_pullup), 32'h20);
        rc(IDX_C_DATA, 32'h3A);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rc(IDX_B_DIR, 32'h0);
        ck(32'(second_port_pins_oe), 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
